// >>> inc/pcc_pkg.sv
package pcc_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] PCC_BRN_OFS   = 12'h054;
  localparam logic [11:0] PCC_LOCK_OFS  = 12'h058;
  localparam logic [11:0] PCC_BG_OFS    = 12'h05c;
  localparam logic [11:0] PCC_SUP_OFS   = 12'h060;
  localparam logic [11:0] PCC_TEST_OFS  = 12'h06c;
  localparam logic [11:0] PCC_PLL_OFS   = 12'h078;
  localparam logic [11:0] PCC_GATE_OFS  = 12'h07c;

  // ----------------------------------------------------------------
  // writable masks and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] PCC_BRN_MASK  = 32'h0000_000b;
  localparam logic [31:0] PCC_BRN_RST   = 32'h0000_0000;
  localparam logic [31:0] PCC_LOCK_MASK = 32'hffff_fffb;
  localparam logic [31:0] PCC_LOCK_RST  = 32'h0000_0000;
  localparam int          PCC_LOCK_BIT  = 2;
  localparam logic [31:0] PCC_BG_MASK   = 32'h0000_07ff;
  localparam logic [31:0] PCC_BG_RST    = 32'h0000_0024;
  localparam logic [31:0] PCC_SUP_MASK  = 32'h0000_0007;
  localparam logic [31:0] PCC_SUP_RST   = 32'h0000_0003;
  localparam logic [31:0] PCC_TEST_MASK = 32'h0000_03ff;
  localparam logic [31:0] PCC_TEST_RST  = 32'h0000_0000;
  localparam logic [31:0] PCC_PLL_MASK  = 32'h001f_ffff;
  localparam logic [31:0] PCC_PLL_RST   = 32'h0000_aaab;
  localparam logic [31:0] PCC_GATE_MASK = 32'hceeb_8ff2;
  localparam logic [31:0] PCC_GATE_RST  = 32'h04fa_0f90;

  // ----------------------------------------------------------------
  // ahb-lite encodings
  // ----------------------------------------------------------------
  localparam logic [1:0]  PCC_HTRANS_NSEQ = 2'h2;
  localparam logic [1:0]  PCC_HTRANS_SEQ  = 2'h3;
  localparam int          PCC_NGATES      = 32;
endpackage

// >>> hw/pcc_sync2.sv
`timescale 1ns/10ps
// ------------------------------------------------------------------
// two-flop level synchroniser
// ------------------------------------------------------------------
module pcc_sync2 (
  input  wire logic hclk,     // system clock
  input  wire logic hresetn,  // async reset, active low
  input  wire logic din,      // asynchronous level
  output logic      dout      // synchronised level
);
  typedef struct packed {
    logic s1;
    logic s2;
  } pcc_sync_s;

  pcc_sync_s st_r;
  pcc_sync_s st_nxt;

  // first stage feeds only the second
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.s2;
endmodule // pcc_sync2

// >>> hw/pcc_clk_gate.sv
`timescale 1ns/10ps
// ------------------------------------------------------------------
// latch-based glitch-free clock gate
// ------------------------------------------------------------------
module pcc_clk_gate (
  input  wire logic clk_in,   // clock to gate
  input  wire logic enable,   // gate enable, same domain
  output logic      clk_out   // gated clock
);
  logic en_lat;

  // enable only changes while the clock is low
  always_latch begin
    if (!clk_in) begin
      en_lat <= enable;
    end
  end

  assign clk_out = clk_in & en_lat;
endmodule // pcc_clk_gate

// >>> hw/pcc_regs.sv
`timescale 1ns/10ps
// Functional notes
// - three brown-out reset enables, cleared at reset
// - pll lock read-only bit two, rest storage
// - external 1.8v supply flag to sequencer
// - two-bit handshake delay select, reset three
// - test mux enables and selects
// - pll fraction 0xaaab and power-up bit
// - listed peripheral clocks enabled after reset
// - usb bus and core clocks off
// - sdio bus and function clocks off
// - bandgap and oscillator controls to analog
module pcc_regs
  import pcc_pkg::*;
(
  input  wire logic        hclk,                         // system clock
  input  wire logic        hresetn,                      // async reset, active low
  input  wire logic        hsel,                         // slave select
  input  wire logic [31:0] haddr,                        // address
  input  wire logic [1:0]  htrans,                       // transfer type
  input  wire logic        hwrite,                       // write strobe
  input  wire logic [2:0]  hsize,                        // transfer size
  input  wire logic [31:0] hwdata,                       // write data
  input  wire logic        hready,                       // bus ready in
  output logic      [31:0] hrdata,                       // read data
  output logic             hreadyout,                    // ready out
  output logic             hresp,                        // response, always okay
  input  wire logic        pll_lock_in,                  // audio pll lock, async
  input  wire logic [PCC_NGATES-1:0] periph_clk_in,      // ungated peripheral clocks
  output logic      [PCC_NGATES-1:0] periph_clk_out,     // gated peripheral clocks
  output logic [31:0]      clock_gate_enables,           // gate enable bits
  output logic             analog18_brownout_reset_enable, // 1.8v brown-out reset en
  output logic             battery_brownout_reset_enable,  // battery brown-out reset en
  output logic             core12_brownout_reset_enable,   // 1.2v brown-out reset en
  output logic [29:0]      lock_spare_out,               // lock register storage bits
  output logic             osc_bypass,                   // crystal oscillator bypass
  output logic [2:0]       analog_test_ctrl,             // analog test control
  output logic [1:0]       bandgap_voltage_select,       // bandgap voltage select
  output logic             resistor_orient_select,       // resistor orientation
  output logic             osc_gain_double,              // oscillator gain
  output logic [2:0]       bandgap_trim,                 // bandgap control
  output logic             external_18v_supply,          // external 1.8v rail
  output logic [1:0]       ready_delay_select,           // handshake delay select
  output logic             pm_test_mux_enable,           // pm analog test mux enable
  output logic [3:0]       pm_test_mux_select,           // pm test mux output select
  output logic             aux_test_mux_enable,          // second test mux enable
  output logic [3:0]       aux_test_mux_input,           // second test mux input
  output logic             audio_pll_power_up,           // audio pll power-up
  output logic [19:0]      audio_pll_fraction            // fractional divider
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] brn;
    logic [31:0] lock;
    logic [31:0] bg;
    logic [31:0] sup;
    logic [31:0] test;
    logic [31:0] pll;
    logic [31:0] gate;
    logic        wr_pend;
    logic [11:0] wr_addr;
    logic [31:0] rdata;
  } pcc_state_s;

  pcc_state_s st_r;
  pcc_state_s st_nxt;
  logic       lock_sync;

  // ----------------------------------------------------------------
  // lock input synchroniser
  // ----------------------------------------------------------------
  pcc_sync2 u_lock_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     (pll_lock_in),
    .dout    (lock_sync)
  );

  // masked register update
  function automatic logic [31:0] pcc_upd(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [31:0] msk);
    pcc_upd = (old & ~msk) | (wd & msk);
  endfunction

  // read-back of current state with live lock bit
  function automatic logic [31:0] pcc_read(input pcc_state_s s, input logic [11:0] a,
                                            input logic lk);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      PCC_BRN_OFS:  v = s.brn;
      PCC_LOCK_OFS: v = s.lock | ({31'h0000_0000, lk} << PCC_LOCK_BIT);
      PCC_BG_OFS:   v = s.bg;
      PCC_SUP_OFS:  v = s.sup;
      PCC_TEST_OFS: v = s.test;
      PCC_PLL_OFS:  v = s.pll;
      PCC_GATE_OFS: v = s.gate;
      default:      v = 32'h0000_0000;
    endcase
    pcc_read = v;
  endfunction

  // ----------------------------------------------------------------
  // bus slave: zero wait state, writes land in the data phase
  // ----------------------------------------------------------------
  always_comb begin
    logic        take;
    logic [11:0] a;
    take   = 1'b0;
    a      = 12'h000;
    st_nxt = st_r;
    // data phase of a pending write
    if (st_r.wr_pend) begin
      unique case (st_r.wr_addr)
        PCC_BRN_OFS:  st_nxt.brn  = pcc_upd(st_r.brn, hwdata, PCC_BRN_MASK);
        PCC_LOCK_OFS: st_nxt.lock = pcc_upd(st_r.lock, hwdata, PCC_LOCK_MASK);
        PCC_BG_OFS:   st_nxt.bg   = pcc_upd(st_r.bg, hwdata, PCC_BG_MASK);
        PCC_SUP_OFS:  st_nxt.sup  = pcc_upd(st_r.sup, hwdata, PCC_SUP_MASK);
        PCC_TEST_OFS: st_nxt.test = pcc_upd(st_r.test, hwdata, PCC_TEST_MASK);
        PCC_PLL_OFS:  st_nxt.pll  = pcc_upd(st_r.pll, hwdata, PCC_PLL_MASK);
        PCC_GATE_OFS: st_nxt.gate = pcc_upd(st_r.gate, hwdata, PCC_GATE_MASK);
        default:      st_nxt.gate = st_r.gate;
      endcase
    end
    // address phase
    take             = hsel & hready & (htrans == PCC_HTRANS_NSEQ || htrans == PCC_HTRANS_SEQ);
    a                = {haddr[11:2], 2'h0};
    st_nxt.wr_pend   = take & hwrite;
    st_nxt.wr_addr   = a;
    if (take && !hwrite) begin
      st_nxt.rdata = pcc_read(st_r, a, lock_sync);
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r.brn     <= PCC_BRN_RST;
      st_r.lock    <= PCC_LOCK_RST;
      st_r.bg      <= PCC_BG_RST;
      st_r.sup     <= PCC_SUP_RST;
      st_r.test    <= PCC_TEST_RST;
      st_r.pll     <= PCC_PLL_RST;
      st_r.gate    <= PCC_GATE_RST;
      st_r.wr_pend <= 1'b0;
      st_r.wr_addr <= 12'h000;
      st_r.rdata   <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // gated peripheral clocks
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < PCC_NGATES; g++) begin : g_gate
      pcc_clk_gate u_gate (
        .clk_in  (periph_clk_in[g]),
        .enable  (st_r.gate[g]),
        .clk_out (periph_clk_out[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // outputs, all but the constant hreadyout and hresp straight from the state register
  // ----------------------------------------------------------------
  assign hrdata                         = st_r.rdata;
  assign hreadyout                      = 1'b1;
  assign hresp                          = 1'b0;
  assign clock_gate_enables             = st_r.gate;
  assign analog18_brownout_reset_enable = st_r.brn[3];
  assign battery_brownout_reset_enable  = st_r.brn[1];
  assign core12_brownout_reset_enable   = st_r.brn[0];
  assign lock_spare_out                 = {st_r.lock[31:3], st_r.lock[1]};
  assign osc_bypass                     = st_r.bg[10];
  assign analog_test_ctrl               = st_r.bg[9:7];
  assign bandgap_voltage_select         = st_r.bg[6:5];
  assign resistor_orient_select         = st_r.bg[4];
  assign osc_gain_double                = st_r.bg[3];
  assign bandgap_trim                   = st_r.bg[2:0];
  assign external_18v_supply            = st_r.sup[2];
  assign ready_delay_select             = st_r.sup[1:0];
  assign pm_test_mux_enable             = st_r.test[4];
  assign pm_test_mux_select             = st_r.test[3:0];
  assign aux_test_mux_enable            = st_r.test[9];
  assign aux_test_mux_input             = st_r.test[8:5];
  assign audio_pll_power_up             = st_r.pll[20];
  assign audio_pll_fraction             = st_r.pll[19:0];
endmodule // pcc_regs

// >>> verif/pcc_regs_props.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// port checks of the control register block
// ----------------------------------------------------------------
module pcc_regs_props
  import pcc_pkg::*;
(
  input wire logic        hclk,                           // system clock
  input wire logic        hresetn,                        // async reset, active low
  input wire logic        hsel,                           // slave select
  input wire logic [31:0] haddr,                          // address
  input wire logic [1:0]  htrans,                         // transfer type
  input wire logic        hwrite,                         // write strobe
  input wire logic [31:0] hwdata,                         // write data
  input wire logic        hready,                         // bus ready
  input wire logic [31:0] hrdata,                         // read data
  input wire logic        hreadyout,                      // ready out
  input wire logic        hresp,                          // response
  input wire logic [29:0] lock_spare_out,                 // lock storage bits
  input wire logic        osc_bypass,                     // oscillator bypass
  input wire logic [2:0]  analog_test_ctrl,               // analog test control
  input wire logic [1:0]  bandgap_voltage_select,         // bandgap select
  input wire logic        resistor_orient_select,         // resistor orientation
  input wire logic        osc_gain_double,                // oscillator gain
  input wire logic [2:0]  bandgap_trim,                   // bandgap control
  input wire logic        aux_test_mux_enable,            // second mux enable
  input wire logic [3:0]  aux_test_mux_input,             // second mux input
  input wire logic [31:0] clock_gate_enables,             // gate bits
  input wire logic        analog18_brownout_reset_enable, // 1.8v enable
  input wire logic        battery_brownout_reset_enable,  // battery enable
  input wire logic        core12_brownout_reset_enable,   // 1.2v enable
  input wire logic        external_18v_supply,            // external rail
  input wire logic [1:0]  ready_delay_select,             // delay select
  input wire logic        pm_test_mux_enable,             // test mux enable
  input wire logic [3:0]  pm_test_mux_select,             // test mux select
  input wire logic        audio_pll_power_up,             // pll power-up
  input wire logic [19:0] audio_pll_fraction              // pll fraction
);
  localparam logic [31:0] GATE_WM = 32'hceeb_8ff2;
  logic wr_take;
  logic rd_take;
  // address phases taken
  assign wr_take = hsel & hready & htrans[1] & hwrite;
  assign rd_take = hsel & hready & htrans[1] & ~hwrite;
  default clocking pcc_cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_ready_okay: assert property (hreadyout && !hresp) else $error("bus answer not ready okay");
  a_reset_vals: assert property ($rose(hresetn) |-> clock_gate_enables == 32'h04fa_0f90
    && ready_delay_select == 2'h3 && audio_pll_fraction == 20'haaab && !audio_pll_power_up)
    else $error("reset values wrong");
  a_brn_write: assert property ((wr_take && haddr[11:0] == PCC_BRN_OFS) |=> ##1
    {analog18_brownout_reset_enable, battery_brownout_reset_enable, core12_brownout_reset_enable}
    == {$past(hwdata[3]), $past(hwdata[1]), $past(hwdata[0])}) else $error("brown-out bits");
  a_sup_write: assert property ((wr_take && haddr[11:0] == PCC_SUP_OFS) |=> ##1
    {external_18v_supply, ready_delay_select} == $past(hwdata[2:0])) else $error("supply bits");
  a_test_write: assert property ((wr_take && haddr[11:0] == PCC_TEST_OFS) |=> ##1
    {aux_test_mux_enable, aux_test_mux_input, pm_test_mux_enable, pm_test_mux_select}
    == $past(hwdata[9:0])) else $error("test mux");
  a_bg_write: assert property ((wr_take && haddr[11:0] == PCC_BG_OFS) |=> ##1
    {osc_bypass, analog_test_ctrl, bandgap_voltage_select, resistor_orient_select,
    osc_gain_double, bandgap_trim} == $past(hwdata[10:0])) else $error("bandgap bits");
  a_lock_write: assert property ((wr_take && haddr[11:0] == PCC_LOCK_OFS) |=> ##1
    lock_spare_out == {$past(hwdata[31:3]), $past(hwdata[1])}) else $error("lock storage bits");
  a_pll_write: assert property ((wr_take && haddr[11:0] == PCC_PLL_OFS) |=> ##1
    {audio_pll_power_up, audio_pll_fraction} == $past(hwdata[20:0])) else $error("pll bits");
  a_gate_write: assert property ((wr_take && haddr[11:0] == PCC_GATE_OFS) |=> ##1
    (clock_gate_enables & GATE_WM) == ($past(hwdata) & GATE_WM)) else $error("gate bits");
  a_unmapped_rd: assert property ((rd_take && haddr[11:0] == 12'h064) |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
endmodule // pcc_regs_props

bind pcc_regs pcc_regs_props u_pcc_regs_props (.*);

// >>> verif/pcc_regs_tb.sv
`timescale 1ns/10ps
module pcc_regs_tb;
  import pcc_pkg::*;
  typedef struct {logic [11:0] a; logic [31:0] rst, wm, cm;} pcc_row_s;
  logic        hclk, hresetn, hsel, hwrite, pll_lock_in, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, clock_gate_enables, rd, periph_clk_out;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire logic   hready;
  wire logic [31:0] periph_clk_in;
  int          miscompares = 0;
  int          n_compared = 0;
  pcc_row_s    rows [8] = '{
    '{PCC_BRN_OFS, 32'h0, 32'hb, 32'hb}, '{PCC_LOCK_OFS, 32'h0, 32'hffff_fffb, 32'hffff_ffff},
    '{PCC_BG_OFS, 32'h24, 32'h7ff, 32'h7ff}, '{PCC_SUP_OFS, 32'h3, 32'h7, 32'h7},
    '{PCC_TEST_OFS, 32'h0, 32'h3ff, 32'h3ff}, '{PCC_PLL_OFS, 32'haaab, 32'h1f_ffff, 32'h1f_ffff},
    '{PCC_GATE_OFS, 32'h04fa_0f90, 32'hceeb_8ff2, 32'hcffb_8fff},
    '{12'h064, 32'h0, 32'h0, 32'hffff_ffff}};
  // single slave, gated clocks fed from the bus clock
  assign hready = hreadyout;
  assign periph_clk_in = {PCC_NGATES{hclk}};
  pcc_regs u_pcc_regs (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pll_lock_in(pll_lock_in),
    .periph_clk_in(periph_clk_in), .periph_clk_out(periph_clk_out),
    .clock_gate_enables(clock_gate_enables), .analog18_brownout_reset_enable(),
    .battery_brownout_reset_enable(), .core12_brownout_reset_enable(), .lock_spare_out(),
    .osc_bypass(), .analog_test_ctrl(), .bandgap_voltage_select(), .resistor_orient_select(),
    .osc_gain_double(), .bandgap_trim(), .external_18v_supply(), .ready_delay_select(),
    .pm_test_mux_enable(), .pm_test_mux_select(), .aux_test_mux_enable(),
    .aux_test_mux_input(), .audio_pll_power_up(), .audio_pll_fraction()
  );
  // 50 mhz bus clock
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  task automatic test_done();
    if (miscompares == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one single-word transfer, address phase then data phase
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1; htrans <= PCC_HTRANS_NSEQ; hwrite <= w; haddr <= {20'h0, a};
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 100);
    r = hrdata;
    if (n >= 50) begin
      miscompares++;
      test_done();
    end
  endtask
  task automatic rst_scan();
    foreach (rows[i]) begin
      xfer(1'b0, rows[i].a, 32'h0, rd);
      chk(rd & rows[i].cm, rows[i].rst & rows[i].cm);
    end
  endtask
  // stimulus and checks
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; pll_lock_in = 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rst_scan();
    foreach (rows[i]) begin
      xfer(1'b1, rows[i].a, rows[i].wm | rows[i].rst & ~rows[i].wm, rd);
      xfer(1'b0, rows[i].a, 32'h0, rd);
      chk(rd & rows[i].cm, (rows[i].wm | rows[i].rst) & rows[i].cm);
      xfer(1'b1, rows[i].a, rows[i].rst & ~rows[i].wm, rd);
      xfer(1'b0, rows[i].a, 32'h0, rd);
      chk(rd & rows[i].cm, rows[i].rst & ~rows[i].wm & rows[i].cm);
    end
    // lock bit follows the pll and ignores writes
    xfer(1'b1, PCC_LOCK_OFS, 32'h4, rd);
    xfer(1'b0, PCC_LOCK_OFS, 32'h0, rd);
    chk(rd, 32'h0);
    pll_lock_in <= 1'b1;
    repeat (4) @(posedge hclk);
    xfer(1'b0, PCC_LOCK_OFS, 32'h0, rd);
    chk(rd, 32'h4);
    // only the enabled clocks run, and only in the high phase
    xfer(1'b1, PCC_GATE_OFS, 32'h0010_0020, rd);
    @(posedge hclk);
    #5 chk(periph_clk_out, 32'h0010_0020);
    @(negedge hclk);
    #5 chk(periph_clk_out, 32'h0);
    // reset in mid-run restores every register
    pll_lock_in <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    chk(clock_gate_enables, 32'h04fa_0f90);
    hresetn <= 1'b1;
    rst_scan();
    test_done();
  end
endmodule // pcc_regs_tb
